// >>> core/carrier_pci_pkg.sv
// Purpose: shared constants for the carrier pci arbiter and router
// Assumes: requester index 0 is the vme bridge, 1..6 are sites a..f
// Notes:   interrupt vector bit i is site i inta, bit 6+i site i intb
package carrier_pci_pkg;

   // requester count and site count
   localparam int NUM_REQ   = 7;
   localparam int NUM_SITES = 6;
   localparam int NUM_IRQ   = 12;
   localparam int INTB_BASE = 6;

   // requester indices in circular order
   localparam logic [2:0] REQ_VME    = 3'h0;
   localparam logic [2:0] REQ_SITE_A = 3'h1;
   localparam logic [2:0] REQ_LAST   = 3'h6;

   // address/data line feeding each id select
   localparam int AD_SITE_A = 24; // site f sits on line 19
   localparam int AD_SECOND = 25;
   localparam int AD_MEM_1  = 26;
   localparam int AD_BRIDGE = 27;

   // board revision codes
   localparam logic [1:0] REV_RESET  = 2'h0;
   localparam logic [1:0] REV_SHARED = 2'h2; // one common module line
   localparam logic [1:0] REV_PER    = 2'h3; // per site lines, tdm on pci

   // pci clock limits in khz: 25000 and 8000
   localparam logic [15:0] PCI_MAX_KHZ   = 16'h61a8;
   localparam logic [15:0] PCI_MIN_KHZ   = 16'h1f40;
   localparam logic [15:0] PCI_KHZ_RESET = 16'h0000;

   // cycles after reset release before straps are taken
   localparam logic [1:0] BOOT_CYCLES = 2'h3;

   // reset values of grant pins (all released) and irq pins
   localparam logic [6:0] GNT_RESET  = 7'h7f;
   localparam logic [5:0] MODIRQ_OFF = 6'h00;

   // bus activity phases, one-hot
   typedef enum logic [1:0] {
      PHASE_IDLE = 2'b01,
      PHASE_BUSY = 2'b10
   } bus_phase_e;

endpackage

// >>> core/irq_route.sv
// Purpose: steer twelve module interrupt levels to vme and module lines
// Assumes: levels are already synchronised and active high
// Notes:   purely combinational; the caller registers the outputs
`timescale 1ns/100ps
module irq_route (
   input  wire logic [11:0] irq_level,    // bit i inta, bit 6+i intb
   input  wire logic [11:0] vme_mask,     // 1 lets a request to vme
   input  wire logic [5:0]  shared_mask,  // inta enables, common line
   input  wire logic [71:0] site_route,   // 12 enables per target site
   input  wire logic [1:0]  board_rev,    // captured board revision
   output logic             vme_active,   // some enabled request up
   output logic [5:0]       site_active   // per site line wants low
);

   // combine enabled requests per target
   always_comb begin
      logic shared_any;
      shared_any  = 1'b0;
      vme_active  = |(irq_level & vme_mask);
      site_active = 6'h00;
      // common line: inta only, masked per site
      shared_any  = |(irq_level[5:0] & shared_mask);
      if (board_rev >= carrier_pci_pkg::REV_PER) begin
         // each site has its own enable vector
         for (int s = 0; s < 6; s++) begin
            site_active[s] = |(irq_level & site_route[s*12 +: 12]);
         end
      end else if (board_rev == carrier_pci_pkg::REV_SHARED) begin
         // same level delivered to all six sites
         site_active = {6{shared_any}};
      end else begin
         // older boards have no module line
         site_active = 6'h00;
      end
   end

endmodule // irq_route

// >>> core/carrier_pci_arbiter_router.sv
// Purpose: pci arbiter, id select fan-out and interrupt router
// Assumes: all pci inputs share this clock; irq lines are async pins
// Notes:   grants, id selects and irq lines are registered
//
// Notes on behaviour
// - seven requests in, seven grants out
// - circular order: bridge, sites a to f
// - last owner lowest, next ones climb
// - grant goes to highest active priority
// - no requests: grant parks on last owner
// - sites f..a on lines 19..24, bridge 27
// - line 26 memory one, 25 second/tdm
// - pci clock setting never above 25 mhz
// - clock runs steadily, changes only on reset
// - twelve separate requests, each independently routed
// - vme mask selects requests to vme
// - rev 2: masked inta onto common line
// - rev 3: per site lines, selectable sources
`timescale 1ns/100ps
module carrier_pci_arbiter_router (
   input  wire logic        clock,               // pci clock
   input  wire logic        rstn,                // async reset, low
   input  wire logic [6:0]  req_n,               // requests, low
   input  wire logic        frame_n,             // pci frame, low
   input  wire logic        irdy_n,              // pci irdy, low
   input  wire logic [31:0] ad,                  // pci address/data
   input  wire logic [5:0]  inta_n,              // site inta pins
   input  wire logic [5:0]  intb_n,              // site intb pins
   input  wire logic [1:0]  rev_strap,           // board revision pins
   input  wire logic [15:0] pci_khz_setting,     // stored clock request
   input  wire logic [11:0] vme_mask,            // vme enables
   input  wire logic [5:0]  shared_mask,         // rev 2 inta enables
   input  wire logic [71:0] site_route,          // rev 3 enables
   output logic      [6:0]  gnt_n,               // grants, low
   output logic      [5:0]  idsel_site,          // sites a..f
   output logic             idsel_bridge,        // vme bridge
   output logic             idsel_memory_controller_one,
   output logic             idsel_second_memory_or_tdm_resource,
   output logic             second_resource_is_tdm,
   output logic      [15:0] pci_clock_khz,       // synthesizer setting
   output logic             pci_clock_locked,    // setting frozen
   output logic      [1:0]  board_rev,           // captured revision
   output logic             vme_irq_n,           // vme request, low
   output logic      [5:0]  module_irq_n_out,    // open drain data
   output logic      [5:0]  module_irq_n_oe      // high while pulling
);

   // whole register state of the block
   typedef struct packed {
      logic [6:0]  gnt_n;        // grant pins
      logic [6:0]  gnt_prev_n;   // grants seen one cycle back
      logic [2:0]  owner;        // last bus owner
      logic [1:0]  phase;        // bus_phase_e code
      logic [5:0]  idsel_site;   // site id selects
      logic        idsel_br;     // bridge id select
      logic        idsel_m1;     // memory one id select
      logic        idsel_m2;     // second resource id select
      logic        is_tdm;       // second resource is tdm
      logic [1:0]  boot_cnt;     // cycles since release
      logic        boot_done;    // straps captured
      logic [1:0]  rev;          // board revision
      logic [15:0] khz;          // frozen pci clock setting
      logic [1:0]  strap_s1;     // strap sync stage 1
      logic [1:0]  strap_s2;     // strap sync stage 2
      logic [1:0]  strap_s3;     // strap sync stage 3
      logic [11:0] irq_s1;       // irq sync stage 1
      logic [11:0] irq_s2;       // irq sync stage 2
      logic [11:0] irq_s3;       // irq sync stage 3
      logic [11:0] irq_level;    // agreed irq levels
      logic        vme_irq_n;    // vme irq pin
      logic [5:0]  mod_out;      // module line data, always low
      logic [5:0]  mod_oe;       // module line enables
   } state_s;

   state_s st;       // current state
   state_s next_st;  // next state

   logic       vme_active;   // router: vme request wanted
   logic [5:0] site_active;  // router: module lines wanted

   // step one place round the circular order
   function automatic logic [2:0] step(input logic [2:0] idx);
      return (idx == carrier_pci_pkg::REQ_LAST) ?
             carrier_pci_pkg::REQ_VME : 3'(idx + 3'h1);
   endfunction

   // find the active requester with the highest level
   function automatic logic [3:0] pick(input logic [2:0] lo,
                                       input logic [6:0] act);
      logic [2:0] idx;
      logic [3:0] res;
      res = {1'b0, lo};
      idx = lo;
      // walk from level 0 to 6; a later hit outranks earlier ones
      for (int k = 0; k < carrier_pci_pkg::NUM_REQ; k++) begin
         if (act[idx]) begin
            res = {1'b1, idx};
         end
         idx = step(idx);
      end
      return res;
   endfunction

   // index of the grant held, or the old owner if none
   function automatic logic [2:0] held(input logic [6:0] g_n,
                                       input logic [2:0] dflt);
      logic [2:0] r;
      r = dflt;
      for (int k = 0; k < carrier_pci_pkg::NUM_REQ; k++) begin
         if (!g_n[k]) begin
            r = 3'(k);
         end
      end
      return r;
   endfunction

   // keep a clock request inside the allowed band
   function automatic logic [15:0] clamp(input logic [15:0] khz);
      if (khz > carrier_pci_pkg::PCI_MAX_KHZ) begin
         return carrier_pci_pkg::PCI_MAX_KHZ;
      end else if (khz < carrier_pci_pkg::PCI_MIN_KHZ) begin
         return carrier_pci_pkg::PCI_MIN_KHZ;
      end
      return khz;
   endfunction

   // interrupt steering
   irq_route u_route (
      .irq_level   (st.irq_level),
      .vme_mask    (vme_mask),
      .shared_mask (shared_mask),
      .site_route  (site_route),
      .board_rev   (st.rev),
      .vme_active  (vme_active),
      .site_active (site_active)
   );

   // next state logic
   always_comb begin
      logic [3:0] win;
      logic       bus_idle;
      win      = 4'h0;
      bus_idle = frame_n & irdy_n;
      next_st  = st;

      // three stage sync of async pins
      next_st.irq_s1   = {~intb_n, ~inta_n};
      next_st.irq_s2   = st.irq_s1;
      next_st.irq_s3   = st.irq_s2;
      next_st.strap_s1 = rev_strap;
      next_st.strap_s2 = st.strap_s1;
      next_st.strap_s3 = st.strap_s2;
      // accept a level only once stages 2 and 3 agree
      for (int i = 0; i < carrier_pci_pkg::NUM_IRQ; i++) begin
         if (st.irq_s2[i] == st.irq_s3[i]) begin
            next_st.irq_level[i] = st.irq_s3[i];
         end
      end

      // straps and clock setting taken once after release
      if (!st.boot_done) begin
         if (st.boot_cnt != carrier_pci_pkg::BOOT_CYCLES) begin
            next_st.boot_cnt = 2'(st.boot_cnt + 2'h1);
         end else if (st.strap_s2 == st.strap_s3) begin
            // frozen until the next board reset
            next_st.boot_done = 1'b1;
            next_st.rev       = st.strap_s3;
            next_st.khz       = clamp(pci_khz_setting);
         end
      end

      // track which master owns the bus
      next_st.gnt_prev_n = st.gnt_n;
      unique case (st.phase)
         carrier_pci_pkg::PHASE_IDLE: begin
            // a start on an idle bus belongs to the last grantee
            if (!frame_n) begin
               next_st.phase = carrier_pci_pkg::PHASE_BUSY;
               next_st.owner = held(st.gnt_prev_n, st.owner);
            end
         end
         carrier_pci_pkg::PHASE_BUSY: begin
            // wait for frame and irdy both released
            if (bus_idle) begin
               next_st.phase = carrier_pci_pkg::PHASE_IDLE;
            end
         end
         default: begin
            // illegal code recovers to idle
            next_st.phase = carrier_pci_pkg::PHASE_IDLE;
         end
      endcase

      // arbitration, one grant at a time
      win = pick(next_st.owner, ~req_n);
      if (win[3]) begin
         next_st.gnt_n = ~7'(7'h01 << win[2:0]);
      end else begin
         // nobody asks: park on last owner
         next_st.gnt_n = ~7'(7'h01 << next_st.owner);
      end

      // id selects follow their address/data lines
      for (int i = 0; i < carrier_pci_pkg::NUM_SITES; i++) begin
         next_st.idsel_site[i] = ad[carrier_pci_pkg::AD_SITE_A - i];
      end
      next_st.idsel_br = ad[carrier_pci_pkg::AD_BRIDGE];
      next_st.idsel_m1 = ad[carrier_pci_pkg::AD_MEM_1];
      next_st.idsel_m2 = ad[carrier_pci_pkg::AD_SECOND];
      next_st.is_tdm   = (st.rev >= carrier_pci_pkg::REV_PER);

      // interrupt pins
      next_st.vme_irq_n = ~vme_active;
      next_st.mod_out   = carrier_pci_pkg::MODIRQ_OFF;
      next_st.mod_oe    = site_active;
   end

   // state register
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         st            <= '0;
         st.gnt_n      <= carrier_pci_pkg::GNT_RESET;
         st.gnt_prev_n <= carrier_pci_pkg::GNT_RESET;
         st.owner      <= carrier_pci_pkg::REQ_VME;
         st.phase      <= carrier_pci_pkg::PHASE_IDLE;
         st.rev        <= carrier_pci_pkg::REV_RESET;
         st.khz        <= carrier_pci_pkg::PCI_KHZ_RESET;
         st.vme_irq_n  <= 1'b1;
         st.mod_out    <= carrier_pci_pkg::MODIRQ_OFF;
         st.mod_oe     <= carrier_pci_pkg::MODIRQ_OFF;
      end else begin
         st <= next_st;
      end
   end

   // outputs straight from state
   assign gnt_n                               = st.gnt_n;
   assign idsel_site                          = st.idsel_site;
   assign idsel_bridge                        = st.idsel_br;
   assign idsel_memory_controller_one         = st.idsel_m1;
   assign idsel_second_memory_or_tdm_resource = st.idsel_m2;
   assign second_resource_is_tdm              = st.is_tdm;
   assign pci_clock_khz                       = st.khz;
   assign pci_clock_locked                    = st.boot_done;
   assign board_rev                           = st.rev;
   assign vme_irq_n                           = st.vme_irq_n;
   assign module_irq_n_out                    = st.mod_out;
   assign module_irq_n_oe                     = st.mod_oe;

endmodule // carrier_pci_arbiter_router

// >>> sim/pci_arb_checker_asserts.sv
// Purpose: port checks for the pci arbiter and router
// Assumes: bound to the top module, single clock
// Notes:   assertions only, reset disables all
`timescale 1ns/100ps
module pci_arb_checker (
   input wire logic        clock,
   input wire logic        rstn,
   input wire logic [6:0]  req_n,
   input wire logic        frame_n,
   input wire logic [31:0] ad,
   input wire logic [5:0]  inta_n,
   input wire logic [11:0] vme_mask,
   input wire logic [6:0]  gnt_n,
   input wire logic [5:0]  idsel_site,
   input wire logic        idsel_bridge,
   input wire logic        idsel_memory_controller_one,
   input wire logic        idsel_second_memory_or_tdm_resource,
   input wire logic [15:0] pci_clock_khz,
   input wire logic        pci_clock_locked,
   input wire logic [1:0]  board_rev,
   input wire logic        vme_irq_n,
   input wire logic [5:0]  module_irq_n_oe
);
   // one domain for every check
   default clocking dc @(posedge clock);
   endclocking
   default disable iff (!rstn);

   AST_ONE_GRANT: assert property ($onehot0(~gnt_n))
      else $error("two grants at once");
   AST_GRANT_TO_REQ: assert property (
      ~req_n != 7'h00 |=> (~gnt_n & ~$past(req_n)) != 7'h00)
      else $error("grant missed every requester");
   AST_PARK: assert property ((&req_n && frame_n) [*2] |=> $stable(gnt_n))
      else $error("parked grant moved");
   AST_IDSEL_SITE: assert property (
      $past(rstn) |-> idsel_site == $past({ad[19], ad[20], ad[21], ad[22], ad[23], ad[24]}))
      else $error("site id select wrong");
   AST_IDSEL_BASE: assert property (
      $past(rstn) |-> {idsel_bridge, idsel_memory_controller_one,
                       idsel_second_memory_or_tdm_resource} == $past(ad[27:25]))
      else $error("baseboard id select wrong");
   AST_KHZ_MAX: assert property (pci_clock_khz <= carrier_pci_pkg::PCI_MAX_KHZ)
      else $error("pci clock above limit");
   AST_KHZ_FROZEN: assert property (
      pci_clock_locked |=> pci_clock_locked && $stable(pci_clock_khz))
      else $error("pci clock changed while locked");
   AST_VME_QUIET: assert property ((vme_mask == 12'h000) [*2] |=> vme_irq_n)
      else $error("vme request with all masked");
   AST_VME_RAISE: assert property ((!inta_n[0] && vme_mask[0]) [*6] |=> !vme_irq_n)
      else $error("enabled request missed vme");
   AST_SHARED_EQUAL: assert property (
      board_rev == carrier_pci_pkg::REV_SHARED |->
      module_irq_n_oe == 6'h00 || module_irq_n_oe == 6'h3f)
      else $error("common line split");
   AST_SHARED_IDLE: assert property (
      (board_rev == carrier_pci_pkg::REV_SHARED && inta_n == 6'h3f) [*6]
      |=> module_irq_n_oe == 6'h00)
      else $error("common line low without inta");
endmodule // pci_arb_checker

bind carrier_pci_arbiter_router pci_arb_checker u_chk (.*);

// >>> sim/pci_masters.sv
// Purpose: model of the seven pci masters sharing the bus
// Assumes: index 0 is the vme bridge, 1..6 sites a..f
// Notes:   each wanted master runs one short transaction
`timescale 1ns/100ps
module pci_masters (
   input  wire logic       clock,
   input  wire logic       rstn,
   input  wire logic [6:0] want,       // masters with work
   input  wire logic [6:0] gnt_n,      // grants, low
   output logic      [6:0] req_n,      // requests, low
   output logic            frame_n,    // frame, pulled up
   output logic            irdy_n,     // ready, pulled up
   output logic      [2:0] last_start, // master begun last
   output logic      [7:0] n_starts    // transactions begun
);
   logic [6:0] served; // work done, request dropped
   logic [1:0] phase;  // transaction step
   int         g;      // granted master
   // request while work remains
   assign req_n = ~(want & ~served);
   assign g     = $clog2(~gnt_n);
   // start only when granted and bus idle
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         served <= 7'h00;
         phase <= 2'h0;
         frame_n <= 1'b1;
         irdy_n <= 1'b1;
         last_start <= 3'h0;
         n_starts <= 8'h00;
      end else if (phase == 2'h0) begin
         served <= served & want;
         if (gnt_n != 7'h7f && !req_n[g] && frame_n && irdy_n) begin
            served <= (served & want) | (7'h01 << g);
            frame_n <= 1'b0;
            phase <= 2'h2;
            last_start <= 3'(g);
            n_starts <= n_starts + 8'h01;
         end
      end else begin
         // single data phase, then release
         frame_n <= 1'b1;
         irdy_n <= (phase == 2'h1);
         phase <= phase - 2'h1;
      end
   end
endmodule // pci_masters

// >>> sim/tb_top.sv
// Purpose: self-checking bench for the pci arbiter and router
// Assumes: inputs change on the falling clock edge
// Notes:   revision straps change only across a reset
`timescale 1ns/100ps
module tb_top;
   logic        clock = 1'b0, rstn = 1'b1;
   logic [6:0]  want = 7'h00, req_n, gnt_n;
   logic        frame_n, irdy_n, vme_irq_n;
   logic [31:0] ad = 32'h0;
   logic [5:0]  inta_n = 6'h3f, intb_n = 6'h3f;
   logic [1:0]  rev_strap = 2'h3, board_rev;
   logic [15:0] pci_khz_setting = 16'h7530, pci_clock_khz;
   logic [11:0] vme_mask = 12'h000;
   logic [5:0]  shared_mask = 6'h00, idsel_site;
   logic [71:0] site_route = 72'h0;
   logic        idsel_bridge, idsel_memory_controller_one;
   logic        idsel_second_memory_or_tdm_resource, second_resource_is_tdm;
   logic        pci_clock_locked;
   logic [5:0]  module_irq_n_out, module_irq_n_oe;
   logic [2:0]  last_start;
   logic [7:0]  n_starts;
   int          mismatches = 0, n_compared = 0;
   // id selects in address line order, 19 first
   wire  [8:0]  idsel_all = {idsel_bridge, idsel_memory_controller_one,
                             idsel_second_memory_or_tdm_resource, idsel_site[0], idsel_site[1],
                             idsel_site[2], idsel_site[3], idsel_site[4], idsel_site[5]};

   carrier_pci_arbiter_router dut (.*);
   pci_masters masters (.*);

   always #12.5 clock = ~clock;

   // compare and count
   task automatic check(input string what, input logic [15:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic close_out();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task automatic do_reset(input logic [1:0] rev);
      rstn = 1'b0;
      rev_strap = rev;
      repeat (10) @(negedge clock);
      rstn = 1'b1;
   endtask

   // parking, clock clamp and freeze
   task automatic t_boot();
      do_reset(2'h3);
      @(negedge clock);
      check("park", gnt_n, 7'h7e);
      repeat (8) @(negedge clock);
      check("khz", pci_clock_khz, carrier_pci_pkg::PCI_MAX_KHZ);
      check("tdm", second_resource_is_tdm, 1'b1);
      check("locked", pci_clock_locked, 1'b1);
      check("rev", board_rev, 2'h3);
      pci_khz_setting = 16'h2710;
      repeat (3) @(negedge clock);
      check("khz held", pci_clock_khz, carrier_pci_pkg::PCI_MAX_KHZ);
      $display("boot done");
   endtask

   // all seven ask; the parked bridge starts first, then owner minus one wins
   task automatic t_rotate();
      int k, t;
      want = 7'h7f;
      for (k = 0; k < 7; k++) begin
         t = 0;
         while (n_starts == 8'(k) && t < 40) begin
            @(negedge clock);
            t++;
         end
         check("winner", last_start, (k == 0) ? 3'h0 : 3'(7 - k));
      end
      want = 7'h00;
      repeat (6) @(negedge clock);
      // site a went last, so the grant rests there
      check("park last", gnt_n, 7'h7d);
      $display("rotate done");
   endtask

   task automatic t_idsel();
      int l;
      for (l = 19; l < 28; l++) begin
         ad = 32'h1 << l;
         repeat (2) @(negedge clock);
         check("idsel", idsel_all, 9'h001 << (l - 19));
         check("one idsel", 16'($countones(idsel_all)), 16'h0001);
      end
      ad = 32'h0;
      $display("idsel done");
   endtask

   // vme path and per site lines
   task automatic t_irq();
      vme_mask = 12'h001;
      inta_n = 6'h3e;
      intb_n = 6'h3b;
      repeat (8) @(negedge clock);
      check("vme low", vme_irq_n, 1'b0);
      vme_mask = 12'h000;
      site_route = (72'h1 << 36) | (72'h1 << 68);
      repeat (8) @(negedge clock);
      check("vme off", vme_irq_n, 1'b1);
      check("lines", module_irq_n_oe, 6'h28);
      check("line data", module_irq_n_out, 6'h00);
      inta_n = 6'h3f;
      intb_n = 6'h3f;
      repeat (8) @(negedge clock);
      check("released", module_irq_n_oe, 6'h00);
      $display("irq done");
   endtask

   // common line: inta only
   task automatic t_rev2();
      site_route = 72'h0;
      shared_mask = 6'h01;
      intb_n = 6'h3e;
      // request far below the floor; clamp must lift it
      pci_khz_setting = 16'h03e8;
      do_reset(2'h2);
      repeat (16) @(negedge clock);
      check("tdm", second_resource_is_tdm, 1'b0);
      check("rev2", board_rev, 2'h2);
      check("khz floor", pci_clock_khz, carrier_pci_pkg::PCI_MIN_KHZ);
      check("intb kept off", module_irq_n_oe, 6'h00);
      inta_n = 6'h3e;
      repeat (8) @(negedge clock);
      check("common", module_irq_n_oe, 6'h3f);
      $display("rev2 done");
   endtask

   initial begin
      t_boot();
      t_rotate();
      t_idsel();
      t_irq();
      t_rev2();
      close_out();
   end

   // watchdog
   initial begin
      repeat (3000) @(posedge clock);
      mismatches++;
      close_out();
   end
endmodule // tb_top
